// ===== daq_pkg.sv
package daq_pkg;

  // ==========================================================
  // Clock and timer base
  // ==========================================================
  localparam int unsigned CLK_HZ   = 25_000_000;
  localparam int unsigned BASE_HZ  = 2_000_000;
  // Fractional divider: add STEP each clock, wrap at MOD
  localparam logic [4:0]  BASE_MOD  = 5'(CLK_HZ / 1_000_000);
  localparam logic [4:0]  BASE_STEP = 5'(BASE_HZ / 1_000_000);
  localparam logic [15:0] DIV_MIN   = 16'h0002;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] OFS_DATA   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SRCSEL = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0c;
  localparam logic [7:0] OFS_GATE   = 8'h10;
  localparam logic [7:0] OFS_DIV1   = 8'h14;
  localparam logic [7:0] OFS_DIV2   = 8'h18;
  localparam logic [7:0] OFS_TRIG   = 8'h1c;
  localparam logic [7:0] OFS_SWTRIG = 8'h20;
  localparam logic [7:0] OFS_GAIN   = 8'h24;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [15:0] RST_DIV  = 16'hffff;
  localparam logic [1:0]  RST_GAIN = 2'h0;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    CONV_OFF  = 2'h0,
    CONV_EOC  = 2'h1,
    CONV_HALF = 2'h2,
    CONV_OFF3 = 2'h3
  } conv_mode_t;

  typedef struct packed {
    logic       pacer_en;
    conv_mode_t conv_mode;
  } irq_sel_t;

  typedef struct packed {
    logic overrun;
    logic fifo_full;
    logic fifo_half;
    logic fifo_empty;
    logic pacer_pend;
    logic conv_pend;
  } status_t;

endpackage : daq_pkg

// ===== pacer_counter.sv
`timescale 1ns/1ps
module pacer_counter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Count input and divisor
  input  wire logic         tick,
  input  wire logic [W-1:0] divisor,
  // One-cycle output pulse every divisor ticks
  output logic              out_pulse
);
  import daq_pkg::*;

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_out_pulse;
  logic [W-1:0] div_eff;

  // ==========================================================
  // Rate generator
  // ==========================================================
  // Divisors below two are clamped, capping rate at one pulse per two ticks
  always_comb begin
    div_eff        = (divisor < W'(DIV_MIN)) ? W'(DIV_MIN) : divisor;
    next_count     = count;
    next_out_pulse = 1'b0;
    if (tick) begin
      if (count <= W'(1)) begin
        next_count     = div_eff; // Longer divisor takes effect on reload
        next_out_pulse = 1'b1;
      end else begin
        next_count = count - W'(1);
      end
    end
    // A shorter divisor cuts a long stale count at once, so moving from the
    // 0xffff reset rate to a fast rate does not wait out a whole old period
    if (next_count > div_eff) begin
      next_count = div_eff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= '0;
      out_pulse <= 1'b0;
    end else begin
      count     <= next_count;
      out_pulse <= next_out_pulse;
    end
  end

endmodule : pacer_counter

// ===== sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Write side
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  // Read side
  input  wire logic         rd_pop,
  output logic [W-1:0]      rd_data,
  // Fill flags
  output logic              empty,
  output logic              full,
  output logic              half,
  output logic              dropped
);
  import daq_pkg::*;

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0]   level, next_level;
  logic          do_wr, do_rd;

  // ==========================================================
  // Pointers and level
  // ==========================================================
  // Writes while full are thrown away until software drains
  always_comb begin
    do_wr       = wr_valid && !full;
    do_rd       = rd_pop && !empty;
    next_wr_ptr = do_wr ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + AW'(1) : rd_ptr;
    next_level  = level + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level  <= next_level;
    end
  end

  // Storage has no reset; contents are don't-care until written
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_ptr];
  assign empty   = (level == '0);
  assign full    = (level == (AW+1)'(DEPTH));
  assign half    = (level >= (AW+1)'(DEPTH / 2));
  assign dropped = wr_valid && full;

endmodule : sample_fifo

// ===== daq_dual_interrupt_pacer.sv
// Function
// - End-of-conversion raises first request when selected and FIFO not full
// - FIFO reaching 512 raises first request
// - Samples are 16-bit two's complement
// - Two requests can be pending together
// - Both requests merge onto one interrupt line
// - First source is EOC or half-full
// - Second source is pacer timer only
// - Source select bits, each can disable
// - Per-source pending status readable
// - Controller gate on combined interrupt
// - Counters one and two cascade from 2 MHz
// - Pacer rate from base/4 down
// - Pacer drives trigger and second request
// - FIFO holds 1024 words
// - Full FIFO discards new results
`timescale 1ns/1ps
module daq_dual_interrupt_pacer #(
  parameter int  DEPTH     = 1024,
  parameter int  AW        = 10,
  parameter int  DIV_W     = 16,
  parameter bit  HIGH_GAIN = 1'b1
) (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter pins
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_sample,
  output logic             adc_start,
  output logic [1:0]       gain_code,
  // Merged interrupt toward the bus controller
  output logic             irq_line_n
);
  import daq_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  irq_sel_t          irq_source_select_reg, next_sel;
  logic              gate_en, next_gate_en;
  logic              trig_en, next_trig_en;
  logic [DIV_W-1:0]  div1, div2, next_div1, next_div2;
  logic [1:0]        next_gain_code;
  logic              sw_trig, next_sw_trig;
  logic [31:0]       next_prdata;
  logic              next_pready, next_pslverr;
  logic              conversion_irq_request, next_conv_req;
  logic              pacer_irq_request, next_pacer_req;
  logic              overrun, next_overrun;
  logic              next_irq_line_n, next_adc_start;
  logic              half_q, next_half_q;
  logic [4:0]        base_acc, next_base_acc;
  logic              base_tick, next_base_tick;
  logic              done_s1, done_s2, done_s3;
  logic [15:0]       sample_s1, sample_s2;
  logic              eoc_evt, half_evt, pacer_pulse, cnt1_pulse;
  logic              acc_done, wr_done, rd_done, addr_ok, pop;
  logic [15:0]       fifo_q;
  logic              f_empty, f_full, f_half, f_drop;
  logic [9:0]        gain_value;
  status_t           stat;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  // Converter strobe and word come from outside this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_s1   <= 1'b0;
      done_s2   <= 1'b0;
      done_s3   <= 1'b0;
      sample_s1 <= 16'h0000;
      sample_s2 <= 16'h0000;
    end else begin
      done_s1   <= adc_done;
      done_s2   <= done_s1;
      done_s3   <= done_s2;
      sample_s1 <= adc_sample;
      sample_s2 <= sample_s1;
    end
  end

  // Word must hold still at the edge that first samples the strobe high
  assign eoc_evt = done_s2 && !done_s3;

  // ==========================================================
  // Sample FIFO
  // ==========================================================
  // Word stored as-is: already signed, 0x7fff top, 0x8000 bottom
  sample_fifo #(
    .W     (16),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_valid (eoc_evt),
    .wr_data  (sample_s2),
    .rd_pop   (pop),
    .rd_data  (fifo_q),
    .empty    (f_empty),
    .full     (f_full),
    .half     (f_half),
    .dropped  (f_drop)
  );

  // ==========================================================
  // Timer base and cascaded pacer counters
  // ==========================================================
  // 25 MHz does not divide to 2 MHz; average rate is exact
  always_comb begin
    next_base_tick = 1'b0;
    next_base_acc  = base_acc + BASE_STEP;
    if (next_base_acc >= BASE_MOD) begin
      next_base_acc  = next_base_acc - BASE_MOD;
      next_base_tick = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_acc  <= 5'h00;
      base_tick <= 1'b0;
    end else begin
      base_acc  <= next_base_acc;
      base_tick <= next_base_tick;
    end
  end

  // Counter one runs on the base, counter two on its output
  pacer_counter #(.W(DIV_W)) u_cnt1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (base_tick),
    .divisor   (div1),
    .out_pulse (cnt1_pulse)
  );

  pacer_counter #(.W(DIV_W)) u_cnt2 (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (cnt1_pulse),
    .divisor   (div2),
    .out_pulse (pacer_pulse)
  );

  // ==========================================================
  // Request latches and merged line
  // ==========================================================
  // Half-full fires once on reaching 512, not while it stays high
  assign half_evt = f_half && !half_q;

  // Set wins over a clear landing in the same cycle
  always_comb begin
    next_half_q    = f_half;
    next_conv_req  = conversion_irq_request;
    next_pacer_req = pacer_irq_request;
    next_overrun   = overrun;
    if (wr_done && (paddr == OFS_CLEAR)) begin
      if (pwdata[0]) next_conv_req = 1'b0;
      if (pwdata[1]) next_pacer_req = 1'b0;
      if (pwdata[2]) next_overrun = 1'b0;
    end
    case (irq_source_select_reg.conv_mode)
      CONV_EOC: begin
        if (eoc_evt && !f_full) next_conv_req = 1'b1;
      end
      CONV_HALF: begin
        if (half_evt) next_conv_req = 1'b1;
      end
      default: begin
      end
    endcase
    if (irq_source_select_reg.pacer_en && pacer_pulse) begin
      next_pacer_req = 1'b1;
    end
    if (f_drop) next_overrun = 1'b1;
    // Both latches are independent, so both may stand at once
    next_irq_line_n = !(gate_en && (next_conv_req || next_pacer_req));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_q                 <= 1'b0;
      conversion_irq_request <= 1'b0;
      pacer_irq_request      <= 1'b0;
      overrun                <= 1'b0;
      irq_line_n             <= 1'b1;
    end else begin
      half_q                 <= next_half_q;
      conversion_irq_request <= next_conv_req;
      pacer_irq_request      <= next_pacer_req;
      overrun                <= next_overrun;
      irq_line_n             <= next_irq_line_n;
    end
  end

  // ==========================================================
  // Conversion start
  // ==========================================================
  // Pacer and software trigger both start the converter
  assign next_adc_start = (trig_en && pacer_pulse) || sw_trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= next_adc_start;
    end
  end

  // ==========================================================
  // Gain readback
  // ==========================================================
  // Volts = value * 10 / (32768 * gain); analog path scales
  always_comb begin
    case (gain_code)
      2'h0:    gain_value = 10'h001;
      2'h1:    gain_value = HIGH_GAIN ? 10'h00a : 10'h002;
      2'h2:    gain_value = HIGH_GAIN ? 10'h064 : 10'h004;
      default: gain_value = HIGH_GAIN ? 10'h3e8 : 10'h008;
    endcase
  end

  // ==========================================================
  // APB slave
  // ==========================================================
  // Ready comes one cycle into the access phase, never zero wait
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite;
  assign rd_done  = acc_done && !pwrite;
  assign pop      = rd_done && (paddr == OFS_DATA);

  assign stat = '{overrun:    overrun,
                  fifo_full:  f_full,
                  fifo_half:  f_half,
                  fifo_empty: f_empty,
                  pacer_pend: pacer_irq_request,
                  conv_pend:  conversion_irq_request};

  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      OFS_DATA:   next_prdata = f_empty ? 32'h0000_0000 : {16'h0000, fifo_q};
      OFS_STATUS: next_prdata = {26'h0, stat};
      OFS_SRCSEL: next_prdata = {29'h0, irq_source_select_reg};
      OFS_CLEAR:  next_prdata = 32'h0000_0000;
      OFS_GATE:   next_prdata = {31'h0, gate_en};
      OFS_DIV1:   next_prdata = {16'h0000, div1};
      OFS_DIV2:   next_prdata = {16'h0000, div2};
      OFS_TRIG:   next_prdata = {31'h0, trig_en};
      OFS_SWTRIG: next_prdata = 32'h0000_0000;
      OFS_GAIN:   next_prdata = {12'h000, 2'h0, gain_value, 6'h00, gain_code};
      default: begin
        next_prdata = 32'h0000_0000;
        addr_ok     = 1'b0;
      end
    endcase
    next_pready  = psel && penable && !pready;
    next_pslverr = next_pready && !addr_ok;
    if (!next_pready) begin
      next_prdata  = 32'h0000_0000;
    end
  end

  // Control registers written only at the completing edge
  always_comb begin
    next_sel       = irq_source_select_reg;
    next_gate_en   = gate_en;
    next_trig_en   = trig_en;
    next_div1      = div1;
    next_div2      = div2;
    next_gain_code = gain_code;
    next_sw_trig   = 1'b0;
    if (wr_done) begin
      case (paddr)
        OFS_SRCSEL: next_sel = irq_sel_t'(pwdata[2:0]);
        OFS_GATE:   next_gate_en = pwdata[0];
        OFS_DIV1:   next_div1 = pwdata[DIV_W-1:0];
        OFS_DIV2:   next_div2 = pwdata[DIV_W-1:0];
        OFS_TRIG:   next_trig_en = pwdata[0];
        OFS_SWTRIG: next_sw_trig = 1'b1;
        OFS_GAIN:   next_gain_code = pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_source_select_reg <= '{pacer_en: 1'b0, conv_mode: CONV_OFF};
      gate_en               <= 1'b0;
      trig_en               <= 1'b0;
      div1                  <= DIV_W'(RST_DIV);
      div2                  <= DIV_W'(RST_DIV);
      gain_code             <= RST_GAIN;
      sw_trig               <= 1'b0;
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end else begin
      irq_source_select_reg <= next_sel;
      gate_en               <= next_gate_en;
      trig_en               <= next_trig_en;
      div1                  <= next_div1;
      div2                  <= next_div2;
      gain_code             <= next_gain_code;
      sw_trig               <= next_sw_trig;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr;
    end
  end

endmodule : daq_dual_interrupt_pacer

// ===== daq_dual_interrupt_pacer_props.sv
`timescale 1ns/1ps
module daq_dual_interrupt_pacer_props
  import daq_pkg::*;
(
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter and interrupt pins
  input wire logic        adc_done,
  input wire logic [15:0] adc_sample,
  input wire logic        adc_start,
  input wire logic [1:0]  gain_code,
  input wire logic        irq_line_n
);
  // ====================
  // Helpers
  // ====================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed access and any write in flight
  wire acc = psel && penable && pready;
  wire wr  = psel && penable && pwrite;
  wire gwr = acc && pwrite && (paddr == OFS_GAIN);
  wire swr = acc && pwrite && (paddr == OFS_SWTRIG);
  wire gtw = acc && pwrite && (paddr == OFS_GATE);

  // ====================
  // Properties
  // ====================
  property p_rdy; psel && $rose(penable) |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer one cycle into access");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than a cycle");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("read bus not quiet");
  property p_unmap; acc && (paddr > 8'h24) |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  property p_sw; swr |-> ##[2:3] adc_start; endproperty
  a_sw: assert property (p_sw) else $error("software start missing");
  property p_start; adc_start |=> !adc_start [*2]; endproperty
  a_start: assert property (p_start) else $error("start pulse too long");
  property p_gain; !$stable(gain_code) |-> $past(gwr); endproperty
  a_gain: assert property (p_gain) else $error("gain moved without write");
  property p_hold; !irq_line_n && !wr && !$past(wr) |=> !irq_line_n; endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped uncleared");
  // Gate acts one edge late, so a gate write lifts the line two edges on
  property p_rise; $rose(irq_line_n) |-> $past(wr) || $past(gtw, 2); endproperty
  a_rise: assert property (p_rise) else $error("interrupt released by itself");
endmodule : daq_dual_interrupt_pacer_props

// ===== converter_model.sv
`timescale 1ns/1ps
module converter_model #(
  parameter int          CONV_CYC = 8,
  parameter logic [15:0] FIRST    = 16'h8000
) (
  // Clock
  input  wire logic   pclk,
  // Converter pins
  input  wire logic   adc_start,
  output logic        adc_done,
  output logic [15:0] adc_sample
);
  logic [15:0] nxt;

  // Converts on each start; starts during a conversion are missed, as on a real part
  initial begin
    adc_done = 1'b0;
    adc_sample = ~FIRST;
    nxt = FIRST;
    forever begin
      @(posedge pclk);
      if (adc_start === 1'b1) begin
        repeat (CONV_CYC) @(posedge pclk);
        adc_sample <= nxt;
        @(posedge pclk);
        adc_done <= 1'b1;
        repeat (4) @(posedge pclk);
        adc_done <= 1'b0;
        adc_sample <= ~nxt; // Word no longer held
        nxt++;
      end
    end
  end
endmodule : converter_model

// ===== daq_dual_interrupt_pacer_tb_top.sv
`timescale 1ns/1ps
module daq_dual_interrupt_pacer_tb_top;
  import daq_pkg::*;
  // ====================
  // Signals
  // ====================
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        adc_done, adc_start, irq_line_n, e;
  logic [15:0] adc_sample;
  logic [1:0]  gain_code;
  logic [15:0] nxt = 16'h8000;
  int          bad_count = 0;
  int          num_checks = 0;

  daq_dual_interrupt_pacer daq_dual_interrupt_pacer_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .adc_done(adc_done), .adc_sample(adc_sample),
    .adc_start(adc_start), .gain_code(gain_code), .irq_line_n(irq_line_n));
  converter_model converter_model_inst (
    .pclk(pclk), .adc_start(adc_start), .adc_done(adc_done), .adc_sample(adc_sample));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ====================
  // Tasks
  // ====================
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      bad_count++;
      end_of_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_irq(input logic lvl);
    int i;
    for (i = 0; i < 40000 && irq_line_n !== lvl; i++) @(posedge pclk);
    if (i == 40000) begin
      bad_count++;
      end_of_test();
    end
  endtask : wait_irq

  // Drains the FIFO; words must come out in conversion order
  task automatic drain_all(output int n);
    n = 0;
    for (int k = 0; k < 1100; k++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (q[2]) break;
      apb(1'b0, OFS_DATA, 32'h0);
      chk(q, {16'h0, nxt});
      nxt++;
      n++;
    end
  endtask : drain_all

  // ====================
  // Scenarios
  // ====================
  task automatic t_reset();
    apb(1'b0, OFS_SRCSEL, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, OFS_GATE, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, OFS_DIV2, 32'h0);
    chk(q, {16'h0, RST_DIV});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h4);
    apb(1'b0, 8'h28, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, irq_line_n}, 32'h1);
  endtask : t_reset

  task automatic t_gain();
    int f[4] = '{1, 10, 100, 1000};
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, OFS_GAIN, 32'(g));
      apb(1'b0, OFS_GAIN, 32'h0);
      chk(q, 32'(g) | 32'(f[g] << 8));
      chk({30'h0, gain_code}, 32'(g));
    end
  endtask : t_gain

  task automatic t_eoc();
    apb(1'b1, OFS_SRCSEL, 32'h1);
    apb(1'b1, OFS_GATE, 32'h1);
    apb(1'b1, OFS_SWTRIG, 32'h1);
    wait_irq(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    apb(1'b1, OFS_GATE, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_line_n}, 32'h1);
    apb(1'b1, OFS_GATE, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_line_n}, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(q, {16'h0, nxt});
    nxt++;
    apb(1'b1, OFS_CLEAR, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_line_n}, 32'h1);
  endtask : t_eoc

  // Fastest pacer: both stages divide by two, so a pulse every 4 base ticks
  task automatic t_pacer();
    int n;
    apb(1'b1, OFS_DIV1, 32'h2);
    apb(1'b1, OFS_DIV2, 32'h2);
    apb(1'b1, OFS_SRCSEL, 32'h5);
    apb(1'b1, OFS_TRIG, 32'h1);
    for (n = 0; n < 400 && adc_start !== 1'b1; n++) @(posedge pclk);
    @(posedge pclk);
    for (n = 1; n < 400 && adc_start !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, n >= 49 && n <= 51}, 32'h1);
    repeat (150) @(posedge pclk);
    apb(1'b1, OFS_TRIG, 32'h0);
    apb(1'b1, OFS_SRCSEL, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h3, 32'h3);
    apb(1'b1, OFS_CLEAR, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_line_n}, 32'h0);
    apb(1'b1, OFS_CLEAR, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq_line_n}, 32'h1);
    drain_all(n);
  endtask : t_pacer

  task automatic t_fill();
    int n;
    apb(1'b1, OFS_SRCSEL, 32'h2);
    apb(1'b1, OFS_TRIG, 32'h1);
    wait_irq(1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h1b, 32'h9);
    for (n = 0; n < 400; n++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      if (q[4]) break;
      repeat (100) @(posedge pclk);
    end
    repeat (200) @(posedge pclk);
    apb(1'b1, OFS_TRIG, 32'h0);
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(q & 32'h30, 32'h30);
    drain_all(n);
    chk(32'(n), 32'd1024);
  endtask : t_fill

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gain();
    t_eoc();
    t_pacer();
    t_fill();
    end_of_test();
  end
endmodule : daq_dual_interrupt_pacer_tb_top

bind daq_dual_interrupt_pacer daq_dual_interrupt_pacer_props daq_dual_interrupt_pacer_props_inst (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_done(adc_done), .adc_sample(adc_sample), .adc_start(adc_start),
  .gain_code(gain_code), .irq_line_n(irq_line_n));
